/* File: reset_and_boot_strap_control.sv */
// reset ranking, reset scopes, strap capture and boot decode
// assumes all inputs synchronous to clk; sys_rst clears control state,
// loads the power-on cause and drives every scope output high
`timescale 1ns/1ps
`include "rst_boot_map.svh"

module reset_and_boot_strap_control
    import rst_boot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // reset sources, pins active low
    input wire logic power_on_reset_pin_n,
    input wire logic user_reset_pin_n,
    input wire logic [2:0] key3_pressed,
    input wire logic wdt_reset_req,
    input wire logic software_reset_bit,
    // pll state held across user resets
    input wire logic pll_enabled,
    // strap pins and boot header probe result
    input wire strap_t straps,
    input wire logic [2:0] hdr_base_sel,
    input wire logic hdr_at_alt,
    // software clears the recorded cause
    input wire logic cause_clear,
    // reset scope outputs, active high
    output logic system_halt,
    output logic core_reset,
    output logic rtc_reset,
    output logic sdram_cfg_reset,
    output logic syscon_reg_reset,
    output logic pll_reset,
    // configuration and status
    output system_config_t system_config_reg,
    output logic [2:0] power_status_reg,
    output logic wdt_flag_key3,
    output logic wdt_flag_wdt,
    output boot_decode_t boot_cfg,
    output logic [11:0] spi_copy_bytes,
    output logic [31:0] spi_exec_addr,
    output logic [31:0] boot_exec_addr
);

    // ==========================================
    // source ranking
    logic [`RST_SRC_W-1:0] src;
    logic por_act;
    logic user_level_act;
    logic key3_all;

    always_comb
    begin
        key3_all = &key3_pressed;
        src = '0;
        src[`SRC_POR] = ~power_on_reset_pin_n;
        src[`SRC_USER] = ~user_reset_pin_n;
        src[`SRC_KEY3] = key3_all;
        src[`SRC_WDT] = wdt_reset_req;
        src[`SRC_SW] = software_reset_bit;
        por_act = src[`SRC_POR];
        user_level_act = |src[`SRC_SW:`SRC_USER];
    end

    // ==========================================
    // reset state machine
    rst_state_t state_q, state_d;
    logic capture_d, capture_q;
    logic [`RST_SRC_W-1:0] held_q, held_d;

    always_comb
    begin
        state_d = state_q;
        capture_d = 1'b0;
        held_d = src; // a user pin still low at power-on release must be remembered
        case (state_q)
            ST_POR:
            begin
                if (!por_act)
                begin
                    state_d = user_level_act ? ST_USER : ST_RUN;
                    capture_d = ~src[`SRC_USER];
                end
            end
            ST_USER:
            begin
                held_d = held_q | src;
                if (por_act)
                    state_d = ST_POR;
                else if (!user_level_act)
                begin
                    state_d = ST_RUN;
                    capture_d = held_q[`SRC_USER];
                end
            end
            ST_RUN:
            begin
                held_d = src;
                if (por_act)
                    state_d = ST_POR;
                else if (user_level_act)
                    state_d = ST_USER;
            end
            default:
                state_d = ST_POR;
        endcase
        if (por_act)
            state_d = ST_POR;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            state_q <= ST_POR;
            capture_q <= 1'b0;
            held_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            capture_q <= capture_d;
            held_q <= held_d;
        end
    end

    // ==========================================
    // scope outputs
    logic halt_d, core_d, por_scope_d, pll_d;

    always_comb
    begin
        halt_d = (state_d != ST_RUN);
        core_d = halt_d;
        por_scope_d = (state_d == ST_POR);
        // user-level reset leaves rtc, sdram and controller regs alone
        pll_d = por_scope_d | ~pll_enabled;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            system_halt <= 1'b1;
            core_reset <= 1'b1;
            rtc_reset <= 1'b1;
            sdram_cfg_reset <= 1'b1;
            syscon_reg_reset <= 1'b1;
            pll_reset <= 1'b1;
        end
        else
        begin
            system_halt <= halt_d;
            core_reset <= core_d;
            rtc_reset <= por_scope_d;
            sdram_cfg_reset <= por_scope_d;
            syscon_reg_reset <= por_scope_d;
            pll_reset <= pll_d;
        end
    end

    // ==========================================
    // strap capture; straps are sampled one cycle after the pin edge
    // so the pads have settled, and are held through key, watchdog and software resets
    system_config_t cfg_d;
    boot_decode_t dec_d;
    logic [31:0] hdr_base;

    always_comb
    begin
        cfg_d = system_config_reg;
        if (capture_q)
        begin
            cfg_d.latched_wdt_timer_disable = straps.wdt_timer_disable_strap;
            cfg_d.latched_wdt_duration_disable = straps.wdt_duration_disable_strap;
            cfg_d.latched_pullup_select = straps.pullup_select_strap;
            cfg_d.latched_internal_external = straps.internal_external_strap;
            cfg_d.latched_pullup_data = straps.pullup_data_strap;
            cfg_d.latched_mode_strap_hi = straps.mode_straps[1];
            cfg_d.latched_mode_strap_lo = straps.mode_straps[0];
            cfg_d.latched_sync_async = straps.sync_async_strap;
            cfg_d.latched_width = straps.width_straps;
            cfg_d.serial_boot_flag = (straps.mode_straps == `MODE_SERIAL);
        end
    end

    // boot decode from latched bits
    always_comb
    begin
        dec_d = '0;
        dec_d.src = BOOT_INVALID;
        dec_d.first_fetch = `ADDR_RESET_VECTOR;
        dec_d.sync_mem = cfg_d.latched_sync_async;
        if (!cfg_d.latched_internal_external && cfg_d.latched_pullup_data
            && {cfg_d.latched_mode_strap_hi, cfg_d.latched_mode_strap_lo} == `MODE_NORMAL)
        begin
            if (cfg_d.latched_sync_async)
            begin
                dec_d.src = BOOT_EXT_SYNC;
                dec_d.mem_width = cfg_d.latched_width[1] ? `WIDTH_32 : `WIDTH_16;
                dec_d.flash_media = ~cfg_d.latched_width[0];
            end
            else
            begin
                dec_d.src = BOOT_EXT_ASYNC;
                dec_d.mem_width = cfg_d.latched_width[1] ? `WIDTH_32
                    : (cfg_d.latched_width[0] ? `WIDTH_16 : `WIDTH_8);
            end
        end
        else if (cfg_d.latched_internal_external && cfg_d.latched_pullup_data)
        begin
            if (cfg_d.serial_boot_flag)
            begin
                dec_d.src = BOOT_SERIAL;
                dec_d.mem_width = cfg_d.latched_width[1] ? `WIDTH_32 : `WIDTH_16;
            end
            else if ({cfg_d.latched_mode_strap_hi, cfg_d.latched_mode_strap_lo} == `MODE_NORMAL)
            begin
                dec_d.src = BOOT_INT_ROM;
                dec_d.rom_tries_spi = 1'b1;
                if (cfg_d.latched_sync_async)
                    dec_d.mem_width = cfg_d.latched_width[1] ? `WIDTH_32 : `WIDTH_16;
                else
                    dec_d.mem_width = cfg_d.latched_width[1] ? `WIDTH_32
                        : (cfg_d.latched_width[0] ? `WIDTH_16 : `WIDTH_8);
            end
        end
        case (hdr_base_sel) // 0..4 flash candidates, 5 low sync base, else high sync base
            3'h0: hdr_base = `FLASH_BASE_0;
            3'h1: hdr_base = `FLASH_BASE_1;
            3'h2: hdr_base = `FLASH_BASE_2;
            3'h3: hdr_base = `FLASH_BASE_3;
            3'h4: hdr_base = `FLASH_BASE_4;
            3'h5: hdr_base = `SYNC_BASE_LO;
            default: hdr_base = `SYNC_BASE_HI;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            system_config_reg <= '0;
            boot_cfg <= '0;
            spi_copy_bytes <= '0;
            spi_exec_addr <= '0;
            boot_exec_addr <= '0;
        end
        else
        begin
            system_config_reg <= cfg_d;
            boot_cfg <= dec_d;
            spi_copy_bytes <= `SPI_COPY_BYTES;
            spi_exec_addr <= `ADDR_BOOT_BUFFER;
            // header past the first block means code starts at the base itself
            boot_exec_addr <= hdr_at_alt ? hdr_base : hdr_base + `HDR_SKIP;
        end
    end

    // ==========================================
    // cause recording; a new reset wins over a clear in the same cycle
    logic [2:0] cause_d;
    logic key3_flag_d, wdt_flag_d;
    logic entering;

    always_comb
    begin
        entering = (state_q == ST_RUN) && (state_d != ST_RUN);
        cause_d = cause_clear ? `CAUSE_NONE : power_status_reg;
        key3_flag_d = cause_clear ? 1'b0 : wdt_flag_key3;
        wdt_flag_d = cause_clear ? 1'b0 : wdt_flag_wdt;
        if (por_act)
        begin
            cause_d = `CAUSE_POR;
            key3_flag_d = 1'b0;
            wdt_flag_d = 1'b0;
        end
        else if (entering)
        begin
            key3_flag_d = 1'b0;
            wdt_flag_d = 1'b0;
            if (src[`SRC_USER])
                cause_d = `CAUSE_USER;
            else if (src[`SRC_KEY3])
            begin
                cause_d = `CAUSE_USER; // power status shows it as user
                key3_flag_d = 1'b1;
            end
            else if (src[`SRC_WDT])
            begin
                cause_d = `CAUSE_WDT;
                wdt_flag_d = 1'b1;
            end
            else
                cause_d = `CAUSE_SW;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            power_status_reg <= `CAUSE_POR;
            wdt_flag_key3 <= 1'b0;
            wdt_flag_wdt <= 1'b0;
        end
        else
        begin
            power_status_reg <= cause_d;
            wdt_flag_key3 <= key3_flag_d;
            wdt_flag_wdt <= wdt_flag_d;
        end
    end

endmodule

/* File: rst_boot_map.svh */
// constants for the reset and boot strap controller
// assumes inclusion by the package and the top module only
`ifndef RST_BOOT_MAP_SVH
`define RST_BOOT_MAP_SVH

`define WIDTH_CODE_W 2
`define RST_SRC_W 5
// reset source bit positions, strongest first
`define SRC_POR 0
`define SRC_USER 1
`define SRC_KEY3 2
`define SRC_WDT 3
`define SRC_SW 4
// boot mode encodings on the mode pins
`define MODE_NORMAL 2'b00
`define MODE_SERIAL 2'b01
// memory widths in bits
`define WIDTH_8 8'h08
`define WIDTH_16 8'h10
`define WIDTH_32 8'h20
// start and header addresses
`define ADDR_RESET_VECTOR 32'h0000_0000
`define ADDR_BOOT_BUFFER 32'h8001_4000
`define SPI_COPY_BYTES 12'h800
`define HDR_ALT_OFFSET 32'h0000_1000
`define HDR_SKIP 32'h0000_0004
`define SYNC_BASE_LO 32'hc000_0000
`define SYNC_BASE_HI 32'hf000_0000
`define FLASH_BASE_0 32'h1000_0000
`define FLASH_BASE_1 32'h2000_0000
`define FLASH_BASE_2 32'h3000_0000
`define FLASH_BASE_3 32'h6000_0000
`define FLASH_BASE_4 32'h7000_0000
// power status cause codes
`define CAUSE_NONE 3'h0
`define CAUSE_POR 3'h1
`define CAUSE_USER 3'h2
`define CAUSE_KEY3 3'h3
`define CAUSE_WDT 3'h4
`define CAUSE_SW 3'h5

`endif

/* File: rst_boot_pkg.sv */
// types shared by the reset and boot strap controller
// assumes rst_boot_map.svh sits beside this file
`include "rst_boot_map.svh"
package rst_boot_pkg;

    // raw strap pins as sampled
    typedef struct packed {
        logic wdt_timer_disable_strap;
        logic wdt_duration_disable_strap;
        logic pullup_select_strap;
        logic internal_external_strap;
        logic pullup_data_strap;
        logic [1:0] mode_straps;
        logic sync_async_strap;
        logic [`WIDTH_CODE_W-1:0] width_straps;
    } strap_t;

    // latched copy, readable as the system configuration register
    typedef struct packed {
        logic latched_wdt_timer_disable;
        logic latched_wdt_duration_disable;
        logic latched_pullup_select;
        logic latched_internal_external;
        logic latched_pullup_data;
        logic latched_mode_strap_hi;
        logic latched_mode_strap_lo;
        logic latched_sync_async;
        logic [`WIDTH_CODE_W-1:0] latched_width;
        logic serial_boot_flag;
    } system_config_t;

    typedef enum logic [2:0]
    {
        BOOT_EXT_SYNC = 3'h0,
        BOOT_EXT_ASYNC = 3'h1,
        BOOT_SERIAL = 3'h2,
        BOOT_INT_ROM = 3'h3,
        BOOT_INVALID = 3'h4
    } boot_src_t;

    typedef struct packed {
        boot_src_t src;
        logic [7:0] mem_width;
        logic sync_mem;
        logic rom_tries_spi;
        logic flash_media;
        logic [31:0] first_fetch;
    } boot_decode_t;

    typedef enum logic [2:0]
    {
        ST_POR = 3'b001,
        ST_USER = 3'b010,
        ST_RUN = 3'b100
    } rst_state_t;

endpackage

/* File: rst_boot_props.sv */
// assertions on reset scope, cause and latched strap outputs
// assumes binding onto reset_and_boot_strap_control
`timescale 1ns/1ps
module rst_boot_props
    import rst_boot_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // reset sources
    input wire logic power_on_reset_pin_n,
    input wire logic user_reset_pin_n,
    input wire logic [2:0] key3_pressed,
    input wire logic wdt_reset_req,
    input wire logic software_reset_bit,
    input wire logic pll_enabled,
    input wire logic cause_clear,
    // watched outputs
    input wire logic system_halt,
    input wire logic core_reset,
    input wire logic rtc_reset,
    input wire logic sdram_cfg_reset,
    input wire logic syscon_reg_reset,
    input wire logic pll_reset,
    input wire system_config_t system_config_reg,
    input wire logic [2:0] power_status_reg,
    input wire logic wdt_flag_key3
);
    // =====
    // shared terms
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    logic any_src;
    assign any_src = !power_on_reset_pin_n || !user_reset_pin_n || (&key3_pressed)
        || wdt_reset_req || software_reset_bit;
    // power-on scope ends one edge after the pin rises, so three quiet cycles are safe
    sequence past_por;
        power_on_reset_pin_n [*3];
    endsequence
    sequence run_then_user;
        !system_halt ##0 $fell(user_reset_pin_n) ##0 power_on_reset_pin_n;
    endsequence
    // =====
    // properties
    halt_on_src_a: assert property (any_src |-> ##1 (system_halt && core_reset))
        else $error("halt missing while a reset source is active");
    halt_release_a: assert property ($fell(any_src) |-> ##[1:3] !system_halt)
        else $error("halt held after all reset sources dropped");
    por_scope_a: assert property (!power_on_reset_pin_n |-> ##1 (rtc_reset
        && sdram_cfg_reset && syscon_reg_reset && pll_reset))
        else $error("power-on reset left a domain out");
    user_spares_a: assert property (past_por |-> !(rtc_reset || sdram_cfg_reset
        || syscon_reg_reset))
        else $error("user-level reset touched a kept domain");
    pll_kept_a: assert property (past_por ##0 ($past(pll_enabled) && pll_enabled)
        |-> !pll_reset)
        else $error("enabled pll reset outside power-on scope");
    cause_user_a: assert property (run_then_user ##0 !cause_clear
        |-> ##1 power_status_reg == 3'h2)
        else $error("user reset cause not recorded");
    key3_flag_a: assert property (!system_halt && (&key3_pressed)
        && power_on_reset_pin_n && user_reset_pin_n && !cause_clear
        |-> ##1 (wdt_flag_key3 && power_status_reg == 3'h2))
        else $error("three-key reset not flagged");
    serial_flag_a: assert property (system_config_reg.serial_boot_flag ==
        (system_config_reg.latched_internal_external && system_config_reg.latched_pullup_data
        && !system_config_reg.latched_mode_strap_hi
        && system_config_reg.latched_mode_strap_lo))
        else $error("serial boot flag disagrees with latched straps");
endmodule

bind reset_and_boot_strap_control rst_boot_props rst_boot_props_i (.clk(clk),
    .sys_rst(sys_rst), .power_on_reset_pin_n(power_on_reset_pin_n),
    .user_reset_pin_n(user_reset_pin_n), .key3_pressed(key3_pressed),
    .wdt_reset_req(wdt_reset_req), .software_reset_bit(software_reset_bit),
    .pll_enabled(pll_enabled), .cause_clear(cause_clear), .system_halt(system_halt),
    .core_reset(core_reset), .rtc_reset(rtc_reset), .sdram_cfg_reset(sdram_cfg_reset),
    .syscon_reg_reset(syscon_reg_reset), .pll_reset(pll_reset),
    .system_config_reg(system_config_reg), .power_status_reg(power_status_reg),
    .wdt_flag_key3(wdt_flag_key3));

/* File: board_straps.sv */
// strap resistors on the board feeding the strap pins
// assumes the bench raises hold while a capture may happen
`timescale 1ns/1ps
module board_straps
    import rst_boot_pkg::*;
(
    // bench control
    input wire logic hold,
    input wire strap_t fitted,
    // strap pins at the device
    output strap_t straps
);
    // after reset the pins carry traffic, so a late capture sees the wrong level
    assign straps = hold ? fitted : strap_t'(~fitted);
endmodule

/* File: test_reset_and_boot_strap_control.sv */
// self-checking bench for the reset and boot strap controller
// assumes board_straps and the bound checker are compiled with it
`timescale 1ns/1ps
module test_reset_and_boot_strap_control
    import rst_boot_pkg::*;
;
    // =====
    // signals and design
    logic clk, sys_rst, por_n, usr_n, wdt, sw, pll_en, clr, hold, halt, core;
    logic rtc, sdc, scr, pllr, fk3, fwdt, hdr_alt;
    logic [2:0] key3, pst, hsel;
    logic [11:0] spi_n;
    logic [31:0] spi_a, xa;
    logic [31:0] seed = 32'h1b;
    strap_t fitted, straps;
    system_config_t cfg;
    boot_decode_t boot;
    typedef struct {int k; logic [95:0] e;} note_t;
    note_t q[$];
    event chk;
    int n_fail = 0;
    int n_tests = 0;
    board_straps board_straps_i (.hold(hold), .fitted(fitted), .straps(straps));
    reset_and_boot_strap_control reset_and_boot_strap_control_i (.clk(clk),
        .sys_rst(sys_rst), .power_on_reset_pin_n(por_n), .user_reset_pin_n(usr_n),
        .key3_pressed(key3), .wdt_reset_req(wdt), .software_reset_bit(sw),
        .pll_enabled(pll_en), .straps(straps), .hdr_base_sel(hsel), .hdr_at_alt(hdr_alt),
        .cause_clear(clr), .system_halt(halt),
        .core_reset(core), .rtc_reset(rtc), .sdram_cfg_reset(sdc), .syscon_reg_reset(scr),
        .pll_reset(pllr), .system_config_reg(cfg), .power_status_reg(pst),
        .wdt_flag_key3(fk3), .wdt_flag_wdt(fwdt), .boot_cfg(boot),
        .spi_copy_bytes(spi_n), .spi_exec_addr(spi_a), .boot_exec_addr(xa));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // =====
    // helpers
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // only strap sets that the boot table defines
    function automatic strap_t legal(logic [31:0] r);
        strap_t s;
        s = r[9:0];
        s.pullup_data_strap = 1'b1;
        s.pullup_select_strap = 1'b1;
        s.mode_straps[1] = 1'b0;
        if (!s.internal_external_strap) s.mode_straps = 2'b00;
        if (s.mode_straps[0] && s.width_straps == 2'b00) s.width_straps = 2'b01;
        return s;
    endfunction
    function automatic logic serial(strap_t s);
        return s.internal_external_strap && s.mode_straps == 2'b01;
    endfunction
    function automatic logic [7:0] ew(strap_t s);
        if (serial(s)) return (s.width_straps == 2'b01) ? 8'h10 : 8'h20;
        if (s.width_straps[1]) return 8'h20;
        return (s.sync_async_strap || s.width_straps[0]) ? 8'h10 : 8'h08;
    endfunction
    function automatic boot_src_t es(strap_t s);
        if (!s.internal_external_strap) return s.sync_async_strap ? BOOT_EXT_SYNC : BOOT_EXT_ASYNC;
        return s.mode_straps[0] ? BOOT_SERIAL : BOOT_INT_ROM;
    endfunction
    task automatic summarize();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic rep(string nm, logic [95:0] e, logic [95:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_cfg(logic [95:0] e);
        rep("config", e, 96'(cfg));
    endtask
    task automatic cmp_boot(logic [95:0] e);
        rep("boot", e, 96'({boot.src, boot.mem_width, boot.sync_mem, boot.rom_tries_spi,
            boot.flash_media, boot.first_fetch, spi_n, spi_a}));
    endtask
    task automatic cmp_st(logic [95:0] e);
        rep("cause", e, 96'({pst, fk3, fwdt}));
    endtask
    task automatic cmp_exec(logic [95:0] e);
        rep("exec address", e, 96'(xa));
    endtask
    task automatic wait_halt(logic v);
        for (int i = 0; i < 20; i++)
        begin
            @(posedge clk);
            #1;
            if (halt === v) return;
        end
        rep("halt wait", 96'(v), 96'(halt));
        summarize();
    endtask
    // =====
    // result watcher
    initial
    begin
        note_t n;
        forever
        begin
            @(chk);
            while (q.size() > 0)
            begin
                n = q.pop_front();
                case (n.k)
                    0: cmp_cfg(n.e);
                    1: cmp_boot(n.e);
                    3: cmp_exec(n.e);
                    default: cmp_st(n.e);
                endcase
            end
        end
    end
    // =====
    // stimulus: kinds are power pin, user pin, keys, watchdog, software
    initial
    begin
        strap_t s, last;
        int k;
        logic [2:0] hs;
        logic ha;
        static logic [4:0] stx [5] = '{5'h04, 5'h08, 5'h0a, 5'h11, 5'h14};
        static int kinds [12] = '{0, 1, 1, 2, 3, 4, 1, 0, 3, 1, 4, 2};
        // header candidates: five flash bases, then the low and high sync bases
        static logic [31:0] bases [7] = '{32'h1000_0000, 32'h2000_0000, 32'h3000_0000,
            32'h6000_0000, 32'h7000_0000, 32'hc000_0000, 32'hf000_0000};
        sys_rst = 1;
        por_n = 0;
        usr_n = 1;
        key3 = 3'h0;
        wdt = 0;
        sw = 0;
        pll_en = 1;
        clr = 0;
        hold = 1;
        hsel = 3'h0;
        hdr_alt = 0;
        fitted = legal(rnd());
        repeat (10) @(posedge clk);
        sys_rst <= 0;
        for (int i = 0; i < 24; i++)
        begin
            k = kinds[i % 12];
            s = legal(rnd());
            hs = seed[6:4];
            ha = seed[7];
            @(posedge clk);
            fitted <= s;
            hsel <= hs;
            hdr_alt <= ha;
            hold <= 1;
            pll_en <= seed[0];
            case (k)
                0: por_n <= 0;
                1: usr_n <= 0;
                2: key3 <= 3'h7;
                3: wdt <= 1;
                default: sw <= 1;
            endcase
            wait_halt(1);
            repeat (4) @(posedge clk);
            por_n <= 1;
            usr_n <= 1;
            key3 <= seed[3:1] & 3'h6;
            wdt <= 0;
            sw <= 0;
            wait_halt(0);
            repeat (4) @(posedge clk);
            hold <= 0;
            repeat (3) @(posedge clk);
            #1;
            if (k < 2) last = s;
            q.push_back('{0, 96'({last, serial(last)})});
            q.push_back('{1, 96'({es(last), ew(last), last.sync_async_strap,
                es(last) == BOOT_INT_ROM, es(last) == BOOT_EXT_SYNC && !last.width_straps[0],
                32'h0, 12'h800, 32'h8001_4000})});
            q.push_back('{3, 96'(bases[(hs > 3'h6) ? 3'h6 : hs]
                + (ha ? 32'h0 : 32'h4))});
            q.push_back('{2, 96'(stx[k])});
            -> chk;
            $display("test %0d reset kind %0d done", i, k);
        end
        @(posedge clk);
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        repeat (2) @(posedge clk);
        #1;
        q.push_back('{2, 96'(5'h00)});
        -> chk;
        $display("test cause clear done");
        #20;
        summarize();
    end
endmodule
